//--- common/eps_defines.svh
`ifndef EPS_DEFINES_SVH
`define EPS_DEFINES_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define EPS_ADDR_PWM_CONTROL 12'h000
`define EPS_ADDR_SHUTDOWN_CONTROL 12'h004
`define EPS_ADDR_DEADBAND_RESTART 12'h008
`define EPS_ADDR_DUTY_HIGH_BYTE 12'h00c
`define EPS_ADDR_DUTY_SHADOW_BYTE 12'h010
`define EPS_ADDR_PERIOD_TIMER_COUNT 12'h014
`define EPS_ADDR_PERIOD_TIMER_CONTROL 12'h018
`define EPS_ADDR_PERIOD_VALUE 12'h01c
`define EPS_ADDR_STATUS 12'h020
`define EPS_ADDR_PIN_DIRECTION 12'h024
// ----------------------------------------
// field positions
// ----------------------------------------
`define EPS_ASE_BIT 7
`define EPS_RSEN_BIT 7
`define EPS_SRC_HI 6
`define EPS_SRC_LO 4
`define EPS_PSSAC_HI 3
`define EPS_PSSAC_LO 2
`define EPS_PSSBD_HI 1
`define EPS_PSSBD_LO 0
`define EPS_DC_HI 6
`define EPS_DC_LO 0
`define EPS_DCB_HI 5
`define EPS_DCB_LO 4
`define EPS_POL_AC_BIT 1
`define EPS_POL_BD_BIT 0
`define EPS_TRUN_BIT 2
`define EPS_TPS_HI 1
`define EPS_TPS_LO 0
`define EPS_SRC_FLT_BIT 2
`define EPS_SRC_C2_BIT 1
`define EPS_SRC_C1_BIT 0
// ----------------------------------------
// reset values and constants
// ----------------------------------------
`define EPS_RESET_BYTE 8'h00
`define EPS_RESET_PERIOD 8'hff
`define EPS_RESET_DIR 4'hf
`define EPS_PSC_DIV1 6'h00
`define EPS_PSC_DIV4 6'h03
`define EPS_PSC_DIV16 6'h0f
`define EPS_CLK_PER_CYCLE 1
`endif

//--- common/eps_pkg.sv
package eps_pkg;
	typedef enum logic [1:0] {EPS_PSS_LOW, EPS_PSS_HIGH, EPS_PSS_TRI, EPS_PSS_TRI2} eps_pss_t;
	typedef enum {EPS_RUN, EPS_SHUT} eps_state_t;
endpackage

//--- core/eps_pwm_shutdown.sv
// Functional notes
// - restart enable is deadband register bit 7
// - auto restart: status clears when cause gone
// - no restart: status held until software clears
// - output resumes at next period start only
// - status writes ignored while cause active
// - comparator cause is level, blocks clearing
// - writing one to status forces shutdown
// - polarity per pair from control bits 1:0
// - period match flag sets at period start
// - reset makes pins inputs, registers default
// - source select decode of three bits
// - pair shutdown state: low, high, tristate
// - prescaler divides by 1, 4 or 16
// - deadband delays active edges by count
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`include "eps_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module eps_pwm_shutdown (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fault_input_n,
	input wire logic comparator1_out,
	input wire logic comparator2_out,
	output logic bridge_out_a,
	output logic bridge_out_b,
	output logic bridge_out_c,
	output logic bridge_out_d,
	output logic bridge_oe_a,
	output logic bridge_oe_b,
	output logic bridge_oe_c,
	output logic bridge_oe_d
);
	import eps_pkg::*;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] pwm_control_q, shutdown_control_q, deadband_restart_q;
	logic [7:0] duty_high_byte_q, duty_shadow_byte_q, period_timer_count_q;
	logic [7:0] period_timer_control_q, period_value_q;
	logic [1:0] duty_low_q, duty_low_shadow_q;
	logic [1:0] sub_q;
	logic [5:0] psc_q;
	logic [3:0] pin_direction_q;
	logic period_match_flag_q;
	logic [1:0] flt_sync_q, c1_sync_q, c2_sync_q;
	logic hold_q;
	logic pwm_raw_q;
	logic [6:0] db_cnt_q;
	logic db_ok_q;
	logic [6:0] dbn_cnt_q;
	logic dbn_ok_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q;
	logic [3:0] out_q, oe_q;

	wire apb_setup = psel && !penable;
	wire apb_wr = psel && penable && pready_q && pwrite; // commits at the access edge
	wire [2:0] src_sel = shutdown_control_q[`EPS_SRC_HI:`EPS_SRC_LO];
	wire auto_restart_enable = deadband_restart_q[`EPS_RSEN_BIT];
	wire shutdown_event_status = shutdown_control_q[`EPS_ASE_BIT];

	// source decode: each bit enables fault pin, comparator 2, comparator 1
	function automatic logic cause_of(input logic [2:0] sel, input logic flt, input logic c1, input logic c2);
		cause_of = (sel[`EPS_SRC_FLT_BIT] && flt) || (sel[`EPS_SRC_C1_BIT] && c1)
			|| (sel[`EPS_SRC_C2_BIT] && c2);
	endfunction

	// second synchroniser stage feeds logic, first stage feeds only the second
	wire cause_sync = cause_of(src_sel, flt_sync_q[1], c1_sync_q[1], c2_sync_q[1]);
	wire cause_raw = cause_of(src_sel, !fault_input_n, comparator1_out, comparator2_out);
	wire cause_now = cause_sync || cause_raw;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flt_sync_q <= 2'h0;
			c1_sync_q <= 2'h0;
			c2_sync_q <= 2'h0;
		end else begin
			flt_sync_q <= {flt_sync_q[0], !fault_input_n};
			c1_sync_q <= {c1_sync_q[0], comparator1_out};
			c2_sync_q <= {c2_sync_q[0], comparator2_out};
		end
	end

	// ----------------------------------------
	// period timer with prescaler
	// ----------------------------------------
	wire timer_run = period_timer_control_q[`EPS_TRUN_BIT];
	logic [5:0] psc_top;
	always_comb begin
		case (period_timer_control_q[`EPS_TPS_HI:`EPS_TPS_LO])
			2'h0: psc_top = `EPS_PSC_DIV1;
			2'h1: psc_top = `EPS_PSC_DIV4;
			default: psc_top = `EPS_PSC_DIV16;
		endcase
	end
	wire psc_tick = timer_run && (psc_q == psc_top);
	wire tmr_tick = psc_tick && (sub_q == 2'h3);
	wire period_start = tmr_tick && (period_timer_count_q == period_value_q);
	wire wr_count = apb_wr && paddr == `EPS_ADDR_PERIOD_TIMER_COUNT;

	// prescaler, quarter counter for 10-bit resolution, 8-bit count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			psc_q <= 6'h0;
			sub_q <= 2'h0;
			period_timer_count_q <= `EPS_RESET_BYTE;
		end else if (wr_count) begin
			psc_q <= 6'h0;
			sub_q <= 2'h0;
			period_timer_count_q <= pwdata[7:0];
		end else if (timer_run) begin
			psc_q <= psc_tick ? 6'h0 : psc_q + 6'h1;
			if (psc_tick)
				sub_q <= sub_q + 2'h1;
			if (period_start)
				period_timer_count_q <= `EPS_RESET_BYTE;
			else if (tmr_tick)
				period_timer_count_q <= period_timer_count_q + 8'h1;
		end
	end

	// period match flag; hardware set wins over software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			period_match_flag_q <= 1'b0;
		else if (period_start)
			period_match_flag_q <= 1'b1;
		else if (apb_wr && paddr == `EPS_ADDR_STATUS && pwdata[0])
			period_match_flag_q <= 1'b0;
	end

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_control_q <= `EPS_RESET_BYTE;
			deadband_restart_q <= `EPS_RESET_BYTE;
			duty_high_byte_q <= `EPS_RESET_BYTE;
			period_timer_control_q <= `EPS_RESET_BYTE;
			period_value_q <= `EPS_RESET_PERIOD;
			pin_direction_q <= `EPS_RESET_DIR;
		end else if (apb_wr) begin
			case (paddr)
				`EPS_ADDR_PWM_CONTROL: pwm_control_q <= pwdata[7:0];
				`EPS_ADDR_DEADBAND_RESTART: deadband_restart_q <= pwdata[7:0];
				`EPS_ADDR_DUTY_HIGH_BYTE: duty_high_byte_q <= pwdata[7:0];
				`EPS_ADDR_PERIOD_TIMER_CONTROL: period_timer_control_q <= {1'b0, pwdata[6:0]};
				`EPS_ADDR_PERIOD_VALUE: period_value_q <= pwdata[7:0];
				`EPS_ADDR_PIN_DIRECTION: pin_direction_q <= pwdata[3:0];
				default: ;
			endcase
		end
	end

	// shutdown control: config bits plain, status bit set by hardware
	wire wr_sd = apb_wr && paddr == `EPS_ADDR_SHUTDOWN_CONTROL;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shutdown_control_q <= `EPS_RESET_BYTE;
		end else begin
			if (wr_sd)
				shutdown_control_q[`EPS_SRC_HI:0] <= pwdata[`EPS_SRC_HI:0];
			if (cause_sync)
				shutdown_control_q[`EPS_ASE_BIT] <= 1'b1;
			else if (wr_sd && !cause_now)
				shutdown_control_q[`EPS_ASE_BIT] <= pwdata[`EPS_ASE_BIT];
			else if (auto_restart_enable)
				shutdown_control_q[`EPS_ASE_BIT] <= 1'b0;
		end
	end

	// duty shadow loaded at each period start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			duty_shadow_byte_q <= `EPS_RESET_BYTE;
			duty_low_shadow_q <= 2'h0;
		end else if (period_start) begin
			duty_shadow_byte_q <= duty_high_byte_q;
			duty_low_shadow_q <= pwm_control_q[`EPS_DCB_HI:`EPS_DCB_LO];
		end
	end
	always_comb duty_low_q = duty_low_shadow_q;

	// ----------------------------------------
	// pwm generation, hold and deadband
	// ----------------------------------------
	wire [9:0] duty10 = {duty_shadow_byte_q, duty_low_q};
	wire [9:0] pos10 = {period_timer_count_q, sub_q};

	// hold stays until a period begins with status clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hold_q <= 1'b1;
		else if (shutdown_event_status)
			hold_q <= 1'b1;
		else if (period_start)
			hold_q <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pwm_raw_q <= 1'b0;
		else
			pwm_raw_q <= timer_run && (pos10 < duty10);
	end

	// deadband helpers: limit reached, one instruction-cycle step
	function automatic logic db_reached(input logic [6:0] cnt, input logic [6:0] lim);
		db_reached = cnt >= lim;
	endfunction
	function automatic logic [6:0] db_step(input logic [6:0] cnt);
		db_step = cnt + 7'(`EPS_CLK_PER_CYCLE);
	endfunction
	wire [6:0] db_lim = deadband_restart_q[`EPS_DC_HI:`EPS_DC_LO];

	// active-edge delay counted in instruction cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			db_cnt_q <= 7'h0;
			db_ok_q <= 1'b0;
		end else if (!pwm_raw_q) begin
			db_cnt_q <= 7'h0;
			db_ok_q <= 1'b0;
		end else if (db_reached(db_cnt_q, db_lim)) begin
			db_ok_q <= 1'b1;
		end else begin
			db_cnt_q <= db_step(db_cnt_q);
		end
	end

	// same delay for the complementary pair, so both switches never overlap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dbn_cnt_q <= 7'h0;
			dbn_ok_q <= 1'b0;
		end else if (pwm_raw_q) begin
			dbn_cnt_q <= 7'h0;
			dbn_ok_q <= 1'b0;
		end else if (db_reached(dbn_cnt_q, db_lim)) begin
			dbn_ok_q <= 1'b1;
		end else begin
			dbn_cnt_q <= db_step(dbn_cnt_q);
		end
	end

	// ----------------------------------------
	// output stage with shutdown override
	// ----------------------------------------
	function automatic logic [1:0] pss_drive(input logic [1:0] pss);
		case (eps_pss_t'(pss))
			EPS_PSS_LOW: pss_drive = 2'b10; // {oe, level}
			EPS_PSS_HIGH: pss_drive = 2'b11;
			default: pss_drive = 2'b00;
		endcase
	endfunction

	wire [1:0] ac_pss = pss_drive(shutdown_control_q[`EPS_PSSAC_HI:`EPS_PSSAC_LO]);
	wire [1:0] bd_pss = pss_drive(shutdown_control_q[`EPS_PSSBD_HI:`EPS_PSSBD_LO]);
	wire forced = hold_q || cause_raw || shutdown_event_status;
	wire act = db_ok_q;
	wire pol_ac = pwm_control_q[`EPS_POL_AC_BIT];
	wire pol_bd = pwm_control_q[`EPS_POL_BD_BIT];
	// pol bit set means active-low for that pair
	wire lvl_ac = act ^ pol_ac;
	wire lvl_bd = dbn_ok_q ^ pol_bd;
	logic [3:0] out_d, oe_d;
	always_comb begin
		if (forced) begin
			out_d = {bd_pss[0], ac_pss[0], bd_pss[0], ac_pss[0]};
			oe_d = {bd_pss[1], ac_pss[1], bd_pss[1], ac_pss[1]};
		end else begin
			out_d = {lvl_bd, lvl_ac, lvl_bd, lvl_ac};
			oe_d = 4'hf;
		end
		oe_d = oe_d & ~pin_direction_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_q <= 4'h0;
			oe_q <= 4'h0;
		end else begin
			out_q <= out_d;
			oe_q <= oe_d;
		end
	end
	assign {bridge_out_d, bridge_out_c, bridge_out_b, bridge_out_a} = out_q;
	assign {bridge_oe_d, bridge_oe_c, bridge_oe_b, bridge_oe_a} = oe_q;

	// ----------------------------------------
	// apb read and answer
	// ----------------------------------------
	logic [7:0] rd_byte;
	logic rd_hit;
	always_comb begin
		rd_hit = 1'b1;
		case (paddr)
			`EPS_ADDR_PWM_CONTROL: rd_byte = pwm_control_q;
			`EPS_ADDR_SHUTDOWN_CONTROL: rd_byte = shutdown_control_q;
			`EPS_ADDR_DEADBAND_RESTART: rd_byte = deadband_restart_q;
			`EPS_ADDR_DUTY_HIGH_BYTE: rd_byte = duty_high_byte_q;
			`EPS_ADDR_DUTY_SHADOW_BYTE: rd_byte = duty_shadow_byte_q;
			`EPS_ADDR_PERIOD_TIMER_COUNT: rd_byte = period_timer_count_q;
			`EPS_ADDR_PERIOD_TIMER_CONTROL: rd_byte = period_timer_control_q;
			`EPS_ADDR_PERIOD_VALUE: rd_byte = period_value_q;
			`EPS_ADDR_STATUS: rd_byte = {6'h0, hold_q, period_match_flag_q};
			`EPS_ADDR_PIN_DIRECTION: rd_byte = {4'h0, pin_direction_q};
			default: begin
				rd_byte = 8'h00;
				rd_hit = 1'b0;
			end
		endcase
	end

	// one wait-free access phase; data captured in setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= apb_setup;
			pslverr_q <= apb_setup && !rd_hit;
			if (apb_setup && !pwrite)
				prdata_q <= {24'h0, rd_byte};
		end
	end
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
endmodule
`default_nettype wire

//--- sim/eps_bridge_model.sv
`timescale 1ns/10ps
`default_nettype none
module eps_bridge_model (
	input wire logic [3:0] drv,
	input wire logic [3:0] en,
	output logic [3:0] pin
);
	// released pins fall to the pull-down, switch stays off
	assign pin = drv & en;
endmodule
`default_nettype wire

//--- sim/eps_pwm_shutdown_props.sv
`include "eps_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module eps_pwm_shutdown_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic fault_input_n,
	input wire logic comparator1_out,
	input wire logic comparator2_out,
	input wire logic bridge_out_a,
	input wire logic bridge_out_b,
	input wire logic bridge_out_c,
	input wire logic bridge_out_d,
	input wire logic bridge_oe_a,
	input wire logic bridge_oe_b,
	input wire logic bridge_oe_c,
	input wire logic bridge_oe_d
);
	import eps_pkg::*;
	// ----------------------------------------
	// shadow of configuration writes
	// ----------------------------------------
	logic [2:0] src_q;
	logic [3:0] pss_q;
	logic [3:0] dir_q;
	logic [2:0] cnt_q;
	logic wr_s;
	logic cause_s;
	logic [3:0] oe_s;
	// write strobe, selected raw cause, enables
	assign wr_s = psel && penable && pready && pwrite;
	assign cause_s = (src_q[2] && !fault_input_n) || (src_q[1] && comparator2_out) || (src_q[0] && comparator1_out);
	assign oe_s = {bridge_oe_d, bridge_oe_c, bridge_oe_b, bridge_oe_a};
	// shadows follow writes at the access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_q <= 3'h0;
			pss_q <= 4'h0;
			dir_q <= 4'hf;
		end else if (wr_s && paddr == `EPS_ADDR_SHUTDOWN_CONTROL) begin
			src_q <= pwdata[6:4];
			pss_q <= pwdata[3:0];
		end else if (wr_s && paddr == `EPS_ADDR_PIN_DIRECTION) begin
			dir_q <= pwdata[3:0];
		end
	end
	// cycles of unbroken cause, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 3'h0;
		end else if (!cause_s) begin
			cnt_q <= 3'h0;
		end else if (cnt_q != 3'h7) begin
			cnt_q <= cnt_q + 3'h1;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_setup_rdy;
		psel && !penable |=> pready && psel && penable;
	endproperty
	a_setup_rdy: assert property (p_setup_rdy) else $error("no ready after setup");
	property p_rdy_pulse;
		pready |=> !pready;
	endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready held");
	property p_err_data;
		pready && !pwrite && paddr > `EPS_ADDR_PIN_DIRECTION |-> pslverr && prdata == 32'h0;
	endproperty
	a_err_data: assert property (p_err_data) else $error("unmapped read");
	property p_reset_release;
		$rose(presetn) |-> oe_s == 4'h0;
	endproperty
	a_reset_release: assert property (p_reset_release) else $error("pin driven at reset");
	property p_dir_gate;
		(dir_q & $past(dir_q) & $past(dir_q, 2) & oe_s) == 4'h0;
	endproperty
	a_dir_gate: assert property (p_dir_gate) else $error("input pin driven");
	property p_force_ac;
		cause_s && !dir_q[0] && !$past(dir_q[0]) |=> bridge_oe_a == !pss_q[3] && (pss_q[3] || bridge_out_a == pss_q[2]);
	endproperty
	a_force_ac: assert property (p_force_ac) else $error("pair ac not forced");
	property p_force_bd;
		cause_s && !dir_q[1] && !$past(dir_q[1]) |=> bridge_oe_b == !pss_q[1] && (pss_q[1] || bridge_out_b == pss_q[0]);
	endproperty
	a_force_bd: assert property (p_force_bd) else $error("pair bd not forced");
	property p_status_held;
		pready && !pwrite && paddr == `EPS_ADDR_SHUTDOWN_CONTROL && cnt_q == 3'h7 |-> prdata[7];
	endproperty
	a_status_held: assert property (p_status_held) else $error("status clear in cause");
	c_cause: cover property (cnt_q == 3'h7);
	c_unmapped: cover property (pready && pslverr);
	c_write: cover property (pready && pwrite);
endmodule
bind eps_pwm_shutdown eps_pwm_shutdown_props eps_pwm_shutdown_props_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.fault_input_n(fault_input_n), .comparator1_out(comparator1_out), .comparator2_out(comparator2_out),
	.bridge_out_a(bridge_out_a), .bridge_out_b(bridge_out_b),
	.bridge_out_c(bridge_out_c), .bridge_out_d(bridge_out_d),
	.bridge_oe_a(bridge_oe_a), .bridge_oe_b(bridge_oe_b), .bridge_oe_c(bridge_oe_c), .bridge_oe_d(bridge_oe_d)
);
`default_nettype wire

//--- sim/testbench.sv
`include "eps_defines.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; $display("BAD %0t got %h exp %h", $time, a, b); end end
module testbench;
	import eps_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic fault_input_n, comparator1_out, comparator2_out;
	logic bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d;
	logic bridge_oe_a, bridge_oe_b, bridge_oe_c, bridge_oe_d;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pin, oe;
	int err_total, samples_checked, i, s;
	assign oe = {bridge_oe_d, bridge_oe_c, bridge_oe_b, bridge_oe_a};
	// device and far side
	eps_pwm_shutdown eps_pwm_shutdown_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fault_input_n(fault_input_n), .comparator1_out(comparator1_out), .comparator2_out(comparator2_out),
		.bridge_out_a(bridge_out_a), .bridge_out_b(bridge_out_b),
		.bridge_out_c(bridge_out_c), .bridge_out_d(bridge_out_d),
		.bridge_oe_a(bridge_oe_a), .bridge_oe_b(bridge_oe_b), .bridge_oe_c(bridge_oe_c), .bridge_oe_d(bridge_oe_d)
	);
	eps_bridge_model eps_bridge_model_inst (
		.drv({bridge_out_d, bridge_out_c, bridge_out_b, bridge_out_a}),
		.en(oe),
		.pin(pin)
	);
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task automatic stop_test();
		if (err_total == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// apb transfer, held until ready
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n == 50) err_total++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		xfer(1'b1, a, {24'h0, d});
	endtask
	task automatic rdc(input logic [11:0] a, input logic [7:0] e);
		xfer(1'b0, a, 32'h0);
		`CHK(rd, {24'h0, e})
	endtask
	initial begin
		{presetn, psel, penable, pwrite, comparator1_out, comparator2_out} = 6'h00;
		fault_input_n = 1'b1;
		paddr = 12'h000;
		pwdata = 32'h0;
		err_total = 0;
		samples_checked = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		// reset state and unmapped place
		rdc(`EPS_ADDR_PWM_CONTROL, 8'h00);
		rdc(`EPS_ADDR_SHUTDOWN_CONTROL, 8'h00);
		rdc(`EPS_ADDR_DEADBAND_RESTART, 8'h00);
		rdc(`EPS_ADDR_PERIOD_VALUE, 8'hff);
		rdc(`EPS_ADDR_PIN_DIRECTION, 8'h0f);
		`CHK(oe, 4'h0)
		rdc(12'h028, 8'h00);
		`CHK(er, 1'b1)
		// bring-up with pins still inputs
		wr(`EPS_ADDR_PERIOD_VALUE, 8'h03);
		wr(`EPS_ADDR_PWM_CONTROL, 8'h0c);
		wr(`EPS_ADDR_DUTY_HIGH_BYTE, 8'h01);
		wr(`EPS_ADDR_SHUTDOWN_CONTROL, 8'h44);
		wr(`EPS_ADDR_DEADBAND_RESTART, 8'h02);
		wr(`EPS_ADDR_SHUTDOWN_CONTROL, 8'hc4);
		rdc(`EPS_ADDR_SHUTDOWN_CONTROL, 8'hc4);
		wr(`EPS_ADDR_STATUS, 8'h01);
		wr(`EPS_ADDR_PERIOD_TIMER_CONTROL, 8'h04);
		i = 0;
		do begin
			xfer(1'b0, `EPS_ADDR_STATUS, 32'h0);
			i++;
		end while (rd[0] !== 1'b1 && i < 40);
		`CHK(rd[0], 1'b1)
		wr(`EPS_ADDR_PIN_DIRECTION, 8'h00);
		repeat (3) @(posedge pclk);
		`CHK(pin, 4'h5)
		`CHK(oe, 4'hf)
		wr(`EPS_ADDR_STATUS, 8'h01);
		wr(`EPS_ADDR_SHUTDOWN_CONTROL, 8'h44);
		rdc(`EPS_ADDR_SHUTDOWN_CONTROL, 8'h44);
		// hold may only drop together with a period start
		i = 0;
		do begin
			xfer(1'b0, `EPS_ADDR_STATUS, 32'h0);
			i++;
		end while (rd[1] !== 1'b0 && i < 40);
		`CHK(rd[1:0], 2'h1)
		// latched fault without restart
		wr(`EPS_ADDR_SHUTDOWN_CONTROL, 8'h40);
		fault_input_n <= 1'b0;
		repeat (8) @(posedge pclk);
		`CHK({oe, pin}, 8'hf0)
		wr(`EPS_ADDR_SHUTDOWN_CONTROL, 8'h40);
		rdc(`EPS_ADDR_SHUTDOWN_CONTROL, 8'hc0);
		fault_input_n <= 1'b1;
		repeat (8) @(posedge pclk);
		rdc(`EPS_ADDR_SHUTDOWN_CONTROL, 8'hc0);
		wr(`EPS_ADDR_SHUTDOWN_CONTROL, 8'h40);
		rdc(`EPS_ADDR_SHUTDOWN_CONTROL, 8'h40);
		// every nonzero source code against every cause, restart on
		wr(`EPS_ADDR_DEADBAND_RESTART, 8'h80);
		for (s = 1; s < 8; s++) begin
			for (i = 0; i < 3; i++) begin
				wr(`EPS_ADDR_SHUTDOWN_CONTROL, {1'b0, s[2:0], 4'ha});
				comparator1_out <= (i == 0);
				comparator2_out <= (i == 1);
				fault_input_n <= (i != 2);
				repeat (8) @(posedge pclk);
				rdc(`EPS_ADDR_SHUTDOWN_CONTROL, {s[i], s[2:0], 4'ha});
				if (s[i]) `CHK(oe, 4'h0)
				{comparator1_out, comparator2_out, fault_input_n} <= 3'h1;
				repeat (6) @(posedge pclk);
				rdc(`EPS_ADDR_SHUTDOWN_CONTROL, {1'b0, s[2:0], 4'ha});
			end
		end
		// polarity per pair with zero duty, pins released while changing
		wr(`EPS_ADDR_DUTY_HIGH_BYTE, 8'h00);
		repeat (40) @(posedge pclk);
		`CHK(pin, 4'ha)
		wr(`EPS_ADDR_PIN_DIRECTION, 8'h0f);
		wr(`EPS_ADDR_PWM_CONTROL, 8'h03);
		repeat (40) @(posedge pclk);
		wr(`EPS_ADDR_PIN_DIRECTION, 8'h00);
		repeat (3) @(posedge pclk);
		`CHK(pin, 4'h5)
		// prescaler divide by 4 and by 16
		wr(`EPS_ADDR_PERIOD_VALUE, 8'hff);
		wr(`EPS_ADDR_PERIOD_TIMER_CONTROL, 8'h05);
		wr(`EPS_ADDR_PERIOD_TIMER_COUNT, 8'h00);
		repeat (39) @(posedge pclk);
		rdc(`EPS_ADDR_PERIOD_TIMER_COUNT, 8'h02);
		wr(`EPS_ADDR_PERIOD_TIMER_CONTROL, 8'h06);
		wr(`EPS_ADDR_PERIOD_TIMER_COUNT, 8'h00);
		repeat (149) @(posedge pclk);
		rdc(`EPS_ADDR_PERIOD_TIMER_COUNT, 8'h02);
		// reset in mid-run returns defaults
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdc(`EPS_ADDR_SHUTDOWN_CONTROL, 8'h00);
		rdc(`EPS_ADDR_DEADBAND_RESTART, 8'h00);
		rdc(`EPS_ADDR_PIN_DIRECTION, 8'h0f);
		`CHK(oe, 4'h0)
		stop_test();
	end
	// hang guard
	initial begin
		#200000;
		err_total++;
		stop_test();
	end
endmodule
`default_nettype wire
